// ---- design/usw_pkg.sv ----
/*
 * Constants for the serial wire-mode control block: register offsets,
 * field positions, reset values, wire modes and buffer sizes.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
package usw_pkg;
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_STATUS = 8'h00; // Flags and counter
	localparam logic [7:0] OFF_CTRL   = 8'h04; // Enables, mode, clock source
	localparam logic [7:0] OFF_PORT   = 8'h08; // Pin levels and directions
	localparam logic [7:0] OFF_DATA   = 8'h0c; // Shift register
	localparam logic [7:0] OFF_RX     = 8'h10; // Received byte buffer

	// ==========================================================
	// Field positions
	localparam int ST_START = 7; // Start condition flag
	localparam int ST_OVF   = 6; // Counter overflow flag
	localparam int CT_SIE   = 7; // Start interrupt enable
	localparam int CT_OIE   = 6; // Overflow interrupt enable
	localparam int CT_WM    = 4; // Wire mode, two bits
	localparam int CT_CS1   = 3; // Clock source, external
	localparam int CT_CS0   = 2; // Clock source, low bit
	localparam int CT_CLK   = 1; // Strobe or strobe select
	localparam int CT_TC    = 0; // Clock toggle strobe
	localparam int PT_SCL   = 0; // Clock pin level
	localparam int PT_SDA   = 1; // Data pin level
	localparam int PT_DO    = 2; // Data-out pin level
	localparam int PT_SCLD  = 4; // Clock pin direction
	localparam int PT_SDAD  = 5; // Data pin direction
	localparam int PT_DOD   = 6; // Data-out pin direction
	localparam int RX_VALID = 8; // Buffer holds a byte

	// ==========================================================
	// Reset values and sizes
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_PORT = 8'h00;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [3:0] RST_CNT  = 4'h0;
	localparam logic [3:0] CNT_MAX  = 4'hf;
	localparam int         BUF_W    = 8;
	localparam int         BUF_D    = 8;

	// Wire modes in field order
	typedef enum logic [1:0] {WM_OFF, WM_THREE, WM_TWO, WM_TWO_HOLD} usw_wm_t;
endpackage

// ---- design/usw_sync.sv ----
/*
 * Two-flop synchroniser for levels entering the pclk domain.
 * Assumes inputs are asynchronous pin levels that idle high.
 */
`timescale 1ns/100ps
module usw_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q; // First stage, read only by second

	// Two stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Released level, so no false edge follows reset
			meta_q <= '1;
			q      <= '1;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // usw_sync

// ---- design/usw_fifo.sv ----
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; push and pop may coincide.
 */
`timescale 1ns/100ps
module usw_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];     // Storage
	logic [AW-1:0] wp_q, rp_q;  // Pointers
	logic [AW:0]   cnt_q;       // Fill level
	logic          push, pop;

	assign in_ready  = (cnt_q != (AW+1)'(D));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage write
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end

	// Pointers and level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // usw_fifo

// ---- design/usw_ctrl.sv ----
/*
 * Control part of the serial wire unit: transfer counter, clock source
 * select, flags, interrupt requests, wire-mode pin drive and a receive
 * buffer. Assumes an APB master on pclk, asynchronous pin levels and a
 * timer compare pulse from logic on pclk.
 */
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/100ps
module usw_ctrl (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Core side
	input  wire logic        timer_match,
	input  wire logic        global_irq_en,
	output logic             start_irq,
	output logic             overflow_irq,
	// Clock pin
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	output logic             scl_pullup,
	// Data pin
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             sda_pullup,
	// Data-out pin
	output logic             do_out,
	output logic             do_oe,
	output logic             do_pullup
);
	// ==========================================================
	// Declarations
	logic [7:0]  ctrl_q;          // Control register
	logic [7:0]  port_q;          // Pin levels and directions
	logic [7:0]  shift_q;         // Shift register
	logic [7:0]  shift_nx;        // Shift value after this edge
	logic [3:0]  transfer_counter_value_q;
	logic        start_condition_flag_q;
	logic        counter_overflow_flag_q;
	logic        scl_s, sda_s;    // Synchronised pins
	logic        scl_p_q, sda_p_q; // Previous synchronised levels
	logic        scl_rise, scl_fall;
	logic        acc, wr_en, rd_done;
	logic        cnt_wr, st_wr, ctl_wr;
	logic        strobe_w, toggle_w;
	logic        cnt_evt_raw, shift_evt_raw, cnt_evt, shift_evt, ovf_evt;
	logic        start_det, scl_hold;
	logic        buf_ready, buf_valid;
	logic [7:0]  buf_data;
	logic [31:0] rd_d;
	usw_pkg::usw_wm_t wm;
	logic [1:0]  cs;
	logic        clk_sel;

	// Address match, used by every decoder
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// ==========================================================
	// Pin input synchronisers
	usw_sync #(.W(2)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({scl_in, sda_in}),
		.q       ({scl_s, sda_s})
	);

	// Previous levels for edge finding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;

	// ==========================================================
	// APB access: one wait state, effects at the completing edge
	assign acc     = psel & penable;
	assign wr_en   = acc & pready & pwrite;
	assign rd_done = acc & pready & ~pwrite & hit(paddr, usw_pkg::OFF_RX);
	assign st_wr   = wr_en & hit(paddr, usw_pkg::OFF_STATUS);
	assign ctl_wr  = wr_en & hit(paddr, usw_pkg::OFF_CTRL);
	assign cnt_wr  = st_wr;

	// Field views
	assign wm      = usw_pkg::usw_wm_t'(ctrl_q[usw_pkg::CT_WM +: 2]);
	assign cs      = ctrl_q[usw_pkg::CT_CS0 +: 2];
	assign clk_sel = ctrl_q[usw_pkg::CT_CLK];

	// Read data mux
	always_comb begin
		rd_d = 32'h0000_0000;
		if (hit(paddr, usw_pkg::OFF_STATUS)) begin
			rd_d[7:0] = {start_condition_flag_q, counter_overflow_flag_q, 2'b00,
				transfer_counter_value_q};
		end else if (hit(paddr, usw_pkg::OFF_CTRL)) begin
			// Toggle bit always reads zero; strobe bit reads zero unless strobe select is in use
			rd_d[7:0] = {ctrl_q[7:2], ctrl_q[usw_pkg::CT_CS1] & clk_sel, 1'b0};
		end else if (hit(paddr, usw_pkg::OFF_PORT)) begin
			rd_d[7:0] = port_q;
		end else if (hit(paddr, usw_pkg::OFF_DATA)) begin
			rd_d[7:0] = shift_q;
		end else if (hit(paddr, usw_pkg::OFF_RX)) begin
			rd_d[usw_pkg::RX_VALID:0] = {buf_valid, buf_data};
		end
	end

	// Bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc & ~pready;
			if (acc & ~pready) begin
				prdata  <= pwrite ? 32'h0000_0000 : rd_d;
				pslverr <= ~(hit(paddr, usw_pkg::OFF_STATUS) | hit(paddr, usw_pkg::OFF_CTRL)
					| hit(paddr, usw_pkg::OFF_PORT) | hit(paddr, usw_pkg::OFF_DATA)
					| hit(paddr, usw_pkg::OFF_RX));
			end
		end
	end

	// ==========================================================
	// Clock event selection
	// Software strobe only clocks when the written source is software
	assign strobe_w = ctl_wr & pwdata[usw_pkg::CT_CLK] & (pwdata[3:2] == 2'b00);
	// Toggle strobe clocks the counter only with external source and select
	assign toggle_w = ctl_wr & pwdata[usw_pkg::CT_TC];

	assign cnt_evt_raw = (cs == 2'b01 & timer_match)
		| (cs[1] & ~clk_sel & (scl_rise | scl_fall))
		| strobe_w
		| (toggle_w & pwdata[usw_pkg::CT_CS1] & pwdata[usw_pkg::CT_CLK]);

	assign shift_evt_raw = (cs == 2'b01 & timer_match)
		| (cs[1] & (cs[0] ? scl_fall : scl_rise))
		| strobe_w;

	// A full receive buffer stalls counting and shifting
	assign cnt_evt   = cnt_evt_raw & buf_ready;
	assign shift_evt = shift_evt_raw & buf_ready;
	assign ovf_evt   = cnt_evt & ~cnt_wr & (transfer_counter_value_q == usw_pkg::CNT_MAX);

	// ==========================================================
	// Transfer counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transfer_counter_value_q <= usw_pkg::RST_CNT;
		end else if (cnt_wr) begin
			transfer_counter_value_q <= pwdata[3:0];
		end else if (cnt_evt) begin
			transfer_counter_value_q <= transfer_counter_value_q + 4'h1;
		end
	end

	// Shift register: a write wins over a shift
	assign shift_nx = shift_evt ? {shift_q[6:0], sda_s} : shift_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_q <= usw_pkg::RST_DATA;
		end else if (wr_en & hit(paddr, usw_pkg::OFF_DATA)) begin
			shift_q <= pwdata[7:0];
		end else begin
			shift_q <= shift_nx;
		end
	end

	// Receive buffer, filled with the byte at each overflow
	usw_fifo #(.W(usw_pkg::BUF_W), .D(usw_pkg::BUF_D)) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (ovf_evt),
		.in_ready  (buf_ready),
		.in_data   (shift_nx),
		.out_valid (buf_valid),
		.out_ready (rd_done),
		.out_data  (buf_data)
	);

	// ==========================================================
	// Control and port registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= usw_pkg::RST_CTRL;
		end else if (ctl_wr) begin
			ctrl_q <= {pwdata[7:1], 1'b0}; // Toggle strobe is not stored
		end
	end

	// Port bits; toggle strobe flips the clock level regardless of direction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_q <= usw_pkg::RST_PORT;
		end else if (wr_en & hit(paddr, usw_pkg::OFF_PORT)) begin
			port_q <= pwdata[7:0];
		end else if (toggle_w) begin
			port_q[usw_pkg::PT_SCL] <= ~port_q[usw_pkg::PT_SCL];
		end
	end

	// ==========================================================
	// Flags: hardware set wins over a same-cycle clear
	// Start seen as data falling while clock stays high, two-wire only
	assign start_det = wm[1] & scl_s & scl_p_q & sda_p_q & ~sda_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_condition_flag_q <= 1'b0;
		end else if (wm[1] ? start_det : (cnt_evt & ~cnt_wr)) begin
			start_condition_flag_q <= 1'b1;
		end else if (st_wr & pwdata[usw_pkg::ST_START]) begin
			start_condition_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_overflow_flag_q <= 1'b0;
		end else if (ovf_evt) begin
			counter_overflow_flag_q <= 1'b1;
		end else if (st_wr & pwdata[usw_pkg::ST_OVF]) begin
			counter_overflow_flag_q <= 1'b0;
		end
	end

	// Interrupt requests follow pending flags as soon as enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_irq    <= 1'b0;
			overflow_irq <= 1'b0;
		end else begin
			start_irq    <= start_condition_flag_q & ctrl_q[usw_pkg::CT_SIE] & global_irq_en;
			overflow_irq <= counter_overflow_flag_q & ctrl_q[usw_pkg::CT_OIE] & global_irq_en;
		end
	end

	// ==========================================================
	// Pin drive per wire mode
	assign scl_hold = start_condition_flag_q
		| (wm == usw_pkg::WM_TWO_HOLD & counter_overflow_flag_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_out    <= 1'b0;
			scl_oe     <= 1'b0;
			scl_pullup <= 1'b0;
			sda_out    <= 1'b0;
			sda_oe     <= 1'b0;
			sda_pullup <= 1'b0;
			do_out     <= 1'b0;
			do_oe      <= 1'b0;
			do_pullup  <= 1'b0;
		end else begin
			// Plain port behaviour unless overridden below
			scl_out    <= port_q[usw_pkg::PT_SCL];
			scl_oe     <= port_q[usw_pkg::PT_SCLD];
			scl_pullup <= port_q[usw_pkg::PT_SCL] & ~port_q[usw_pkg::PT_SCLD];
			sda_out    <= port_q[usw_pkg::PT_SDA];
			sda_oe     <= port_q[usw_pkg::PT_SDAD];
			sda_pullup <= port_q[usw_pkg::PT_SDA] & ~port_q[usw_pkg::PT_SDAD];
			do_out     <= port_q[usw_pkg::PT_DO];
			do_oe      <= port_q[usw_pkg::PT_DOD];
			do_pullup  <= port_q[usw_pkg::PT_DO] & ~port_q[usw_pkg::PT_DOD];
			case (wm)
				usw_pkg::WM_OFF: begin
					// Ports as set above
				end
				usw_pkg::WM_THREE: begin
					do_out <= shift_q[7];
				end
				usw_pkg::WM_TWO, usw_pkg::WM_TWO_HOLD: begin
					// Open drain: drive low only, no pull-ups
					scl_out    <= 1'b0;
					sda_out    <= 1'b0;
					scl_pullup <= 1'b0;
					sda_pullup <= 1'b0;
					sda_oe     <= port_q[usw_pkg::PT_SDAD]
						& ~(shift_q[7] & port_q[usw_pkg::PT_SDA]);
					scl_oe     <= port_q[usw_pkg::PT_SCLD]
						& (~port_q[usw_pkg::PT_SCL] | scl_hold);
				end
				default: begin
					// Unreachable with two bits
				end
			endcase
		end
	end

	// ==========================================================
	// Checks
	a_cnt_write: assert property (@(posedge pclk) disable iff (!presetn)
		cnt_wr |=> transfer_counter_value_q == $past(pwdata[3:0]))
		else $error("counter write not taken");
	a_cnt_incr: assert property (@(posedge pclk) disable iff (!presetn)
		cnt_evt && !cnt_wr |=> transfer_counter_value_q == $past(transfer_counter_value_q) + 4'h1)
		else $error("counter did not step by one");
	a_tc_clock: assert property (@(posedge pclk) disable iff (!presetn)
		toggle_w && pwdata[3] && pwdata[1] && buf_ready |-> cnt_evt)
		else $error("toggle strobe did not clock counter");
	a_off_ext: assert property (@(posedge pclk) disable iff (!presetn)
		wm == usw_pkg::WM_OFF && cs[1] && !clk_sel && scl_rise && buf_ready |-> cnt_evt)
		else $error("external edge ignored in mode zero");
	a_start_irq: assert property (@(posedge pclk) disable iff (!presetn)
		start_condition_flag_q && ctrl_q[7] && global_irq_en |=> start_irq)
		else $error("start request missing");
	a_ovf_irq: assert property (@(posedge pclk) disable iff (!presetn)
		counter_overflow_flag_q && ctrl_q[6] && global_irq_en |=> overflow_irq)
		else $error("overflow request missing");
	a_off_gpio: assert property (@(posedge pclk) disable iff (!presetn)
		wm == usw_pkg::WM_OFF |=> scl_oe == $past(port_q[4]) && sda_out == $past(port_q[1]))
		else $error("mode zero pins not plain");
	a_do_three: assert property (@(posedge pclk) disable iff (!presetn)
		wm == usw_pkg::WM_THREE |=> do_out == $past(shift_q[7]) && do_oe == $past(port_q[6]))
		else $error("data-out pin wrong");
	a_sda_pull: assert property (@(posedge pclk) disable iff (!presetn)
		wm[1] && port_q[5] && !shift_q[7] |=> sda_oe && !sda_out && !sda_pullup)
		else $error("data line not pulled low");
	a_scl_hold: assert property (@(posedge pclk) disable iff (!presetn)
		wm[1] && port_q[4] && start_condition_flag_q |=> scl_oe && !scl_out && !scl_pullup)
		else $error("clock not held after start");
	a_ovf_hold: assert property (@(posedge pclk) disable iff (!presetn)
		wm == usw_pkg::WM_TWO_HOLD && port_q[4] && counter_overflow_flag_q |=> scl_oe)
		else $error("clock not held after overflow");
	a_ovf_set: assert property (@(posedge pclk) disable iff (!presetn)
		ovf_evt |=> counter_overflow_flag_q && transfer_counter_value_q == 4'h0)
		else $error("overflow flag not set on wrap");
	a_start_keep: assert property (@(posedge pclk) disable iff (!presetn)
		start_condition_flag_q && !(st_wr && pwdata[7]) |=> start_condition_flag_q)
		else $error("start flag lost without clear");
endmodule // usw_ctrl

// ---- test/usw_far_end.sv ----
/*
 * Far-end serial device on the clock and data lines.
 * Assumes both lines carry pull-ups; a released line reads high.
 */
`timescale 1ns/100ps
module usw_far_end (
	// Lines driven by the block
	input  wire logic scl_out,
	input  wire logic scl_oe,
	input  wire logic sda_out,
	input  wire logic sda_oe,
	// Resolved line levels
	output logic      scl_in,
	output logic      sda_in
);
	// ==========================================
	// Line drive
	logic scl_drv; // Low while far end pulls clock
	logic sda_drv; // Low while far end pulls data

	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end

	// Wired-and of both parties and the pull-up
	assign scl_in = (scl_oe ? scl_out : 1'b1) & scl_drv;
	assign sda_in = (sda_oe ? sda_out : 1'b1) & sda_drv;

	// ==========================================
	// Stimulus tasks
	// Clock pulses at 800 ns; line stands still outside
	task automatic clk_pulses(input int n);
		#130;
		repeat (n) begin
			#400 scl_drv = 1'b0;
			#400 scl_drv = 1'b1;
		end
	endtask

	// Data falls while clock high, then clock low
	task automatic start_cond();
		#130 sda_drv = 1'b0;
		#400 scl_drv = 1'b0;
		#400 sda_drv = 1'b1;
		#400 scl_drv = 1'b1;
	endtask
endmodule // usw_far_end

// ---- test/usw_ctrl_tb.sv ----
/*
 * Self-checking bench for the serial wire control block.
 * Assumes the APB slave answers with pready and a far-end model on pins.
 */
`timescale 1ns/100ps
module usw_ctrl_tb;
	// ==========================================
	// Signals
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic        timer_match, global_irq_en, start_irq, overflow_irq;
	logic        scl_in, scl_out, scl_oe, scl_pullup;
	logic        sda_in, sda_out, sda_oe, sda_pullup;
	logic        do_out, do_oe, do_pullup, err;
	int          error_cnt, tests_run;

	// ==========================================
	// Instances
	usw_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_match(timer_match),
		.global_irq_en(global_irq_en), .start_irq(start_irq),
		.overflow_irq(overflow_irq), .scl_in(scl_in), .scl_out(scl_out),
		.scl_oe(scl_oe), .scl_pullup(scl_pullup), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .sda_pullup(sda_pullup),
		.do_out(do_out), .do_oe(do_oe), .do_pullup(do_pullup));
	usw_far_end fe (.scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
		.sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

	// 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ==========================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n >= 20) chk(32'h1, 32'h0);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask

	// Pin outputs after registered update
	task automatic pins(input logic [8:0] e);
		repeat (3) @(posedge pclk);
		chk({23'h0, scl_out, scl_oe, scl_pullup, sda_out, sda_oe, sda_pullup,
			do_out, do_oe, do_pullup}, {23'h0, e});
	endtask

	task automatic tick();
		@(posedge pclk) timer_match <= 1'b1;
		@(posedge pclk) timer_match <= 1'b0;
	endtask

	task automatic results();
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog
	initial begin
		#3000000;
		error_cnt++;
		results();
	end

	// ==========================================
	// Main sequence
	initial begin
		{psel, penable, pwrite, timer_match, global_irq_en} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		error_cnt = 0;
		tests_run = 0;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rc(usw_pkg::OFF_STATUS, 32'h0);
		rc(usw_pkg::OFF_CTRL, 32'h0);
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, err}, 32'h1);
		wr(usw_pkg::OFF_STATUS, 8'h05);
		rc(usw_pkg::OFF_STATUS, 32'h05);
		wr(usw_pkg::OFF_CTRL, 8'h02);
		rc(usw_pkg::OFF_STATUS, 32'h86);
		wr(usw_pkg::OFF_STATUS, 8'h06);
		rc(usw_pkg::OFF_STATUS, 32'h86);
		wr(usw_pkg::OFF_STATUS, 8'h80);
		rc(usw_pkg::OFF_STATUS, 32'h00);
		// Timer source, then wrap to zero
		wr(usw_pkg::OFF_CTRL, 8'h04);
		repeat (3) tick();
		rc(usw_pkg::OFF_STATUS, 32'h83);
		wr(usw_pkg::OFF_STATUS, 8'h8f);
		tick();
		rc(usw_pkg::OFF_STATUS, 32'hc0);
		// Pending flags request at once when enabled
		global_irq_en <= 1'b1;
		wr(usw_pkg::OFF_CTRL, 8'h44);
		pins(9'h000);
		chk({30'h0, start_irq, overflow_irq}, 32'h1);
		wr(usw_pkg::OFF_CTRL, 8'hc4);
		repeat (3) @(posedge pclk);
		chk({30'h0, start_irq, overflow_irq}, 32'h3);
		global_irq_en <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({30'h0, start_irq, overflow_irq}, 32'h0);
		wr(usw_pkg::OFF_STATUS, 8'hc0);
		// External clock counts both edges with outputs off
		wr(usw_pkg::OFF_CTRL, 8'h08);
		fe.clk_pulses(2);
		repeat (6) @(posedge pclk);
		rc(usw_pkg::OFF_STATUS, 32'h84);
		// Negative-edge shift source still counts both clock edges
		wr(usw_pkg::OFF_CTRL, 8'h0c);
		fe.clk_pulses(1);
		repeat (6) @(posedge pclk);
		rc(usw_pkg::OFF_STATUS, 32'h86);
		wr(usw_pkg::OFF_CTRL, 8'h0b);
		rc(usw_pkg::OFF_STATUS, 32'h87);
		rc(usw_pkg::OFF_CTRL, 32'h0a);
		rc(usw_pkg::OFF_PORT, 32'h01);
		// Plain port pins
		wr(usw_pkg::OFF_PORT, 8'h77);
		pins(9'b110110110);
		wr(usw_pkg::OFF_PORT, 8'h07);
		pins(9'b101101101);
		// Three-wire: shift msb on data-out
		wr(usw_pkg::OFF_CTRL, 8'h10);
		wr(usw_pkg::OFF_DATA, 8'h80);
		wr(usw_pkg::OFF_PORT, 8'h43);
		pins(9'b101101110);
		// Two-wire open drain
		wr(usw_pkg::OFF_CTRL, 8'h20);
		wr(usw_pkg::OFF_STATUS, 8'hc0);
		wr(usw_pkg::OFF_PORT, 8'h32);
		pins(9'b010000000);
		wr(usw_pkg::OFF_DATA, 8'h00);
		pins(9'b010010000);
		wr(usw_pkg::OFF_DATA, 8'h80);
		wr(usw_pkg::OFF_PORT, 8'h33);
		pins(9'b000000000);
		// Start condition holds the clock line
		fe.start_cond();
		repeat (4) @(posedge pclk);
		rc(usw_pkg::OFF_STATUS, 32'h80);
		pins(9'b010000000);
		wr(usw_pkg::OFF_STATUS, 8'h80);
		pins(9'b000000000);
		// Mode three holds after overflow
		wr(usw_pkg::OFF_CTRL, 8'h30);
		wr(usw_pkg::OFF_PORT, 8'h13);
		wr(usw_pkg::OFF_STATUS, 8'h0f);
		wr(usw_pkg::OFF_CTRL, 8'h32);
		pins(9'b010000000);
		wr(usw_pkg::OFF_STATUS, 8'h40);
		pins(9'b000000000);
		// Fill the buffer until overflows are refused
		wr(usw_pkg::OFF_CTRL, 8'h00);
		repeat (6) begin
			wr(usw_pkg::OFF_STATUS, 8'h0f);
			wr(usw_pkg::OFF_CTRL, 8'h02);
		end
		wr(usw_pkg::OFF_STATUS, 8'hcf);
		wr(usw_pkg::OFF_CTRL, 8'h02);
		rc(usw_pkg::OFF_STATUS, 32'h0f);
		repeat (8) begin
			apb(1'b0, usw_pkg::OFF_RX, 32'h0);
			chk({31'h0, rdv[8]}, 32'h1);
		end
		apb(1'b0, usw_pkg::OFF_RX, 32'h0);
		chk({31'h0, rdv[8]}, 32'h0);
		wr(usw_pkg::OFF_CTRL, 8'h02);
		rc(usw_pkg::OFF_STATUS, 32'hc0);
		results();
	end
endmodule // usw_ctrl_tb
